// ---- design/ext_irq_defs.vh ----
`ifndef EXT_IRQ_DEFS_VH
`define EXT_IRQ_DEFS_VH
// register byte addresses (AXI4-Lite, one word each)
`define ADDR_PIN_STATUS_CONTROL 5'h00
`define ADDR_KEYPAD_STATUS_CONTROL 5'h04
`define ADDR_KEYPAD_ENABLE 5'h08
`define ADDR_SECOND_CONFIG 5'h0C
`define ADDR_BREAK_FLAG_CONTROL 5'h10
// status/control field positions (shared layout for pin and keypad)
`define SC_MODE_BIT 0
`define SC_MASK_BIT 1
`define SC_ACK_BIT 2
`define SC_FLAG_BIT 3
// second configuration register fields
`define CFG2_FUNC_EN_BIT 1
`define CFG2_PULLUP_DIS_BIT 0
// break flag control field
`define BFC_CLEAR_EN_BIT 7
// reset values
`define RST_STATUS_CONTROL 8'h00
`define RST_KEYPAD_ENABLE 6'h00
`define RST_SECOND_CONFIG 8'h00
`define RST_BREAK_FLAG_CONTROL 8'h00
// vector fetch addresses, kept for reference by the CPU side
`define VEC_PIN_HI 16'hFFFA
`define VEC_PIN_LO 16'hFFFB
`define VEC_KEYPAD_HI 16'hFFE0
`define VEC_KEYPAD_LO 16'hFFE1
// address of the second configuration register in the device map
`define SECOND_CONFIG_DEVICE_ADDR 16'h001E
`endif

// ---- design/external_interrupt_inputs.v ----
// Behaviour
// RQ1 - pin falling edge sets pin latch; vector fetch, software ack or reset clears it
// RQ2 - level mode: pin request clears only after acknowledge and pin high, any order
// RQ3 - writing 1 to pin ack bit clears latch; bit reads 0, reset clears
// RQ4 - acknowledge write never blocks later edges; new falling edge latches again
// RQ5 - latched and unmasked pin request goes to CPU, vector FFFA/FFFB
// RQ6 - reset clears pin latch and sensitivity bit even with pin low
// RQ7 - edge mode: fetch or software ack clears pin latch at once
// RQ8 - pin pending flag reads latch state, independent of mask; in level mode the code also sets it while the pin is low
// RQ9 - function on: branch sees pin level, port A bit two reads 0; off: 1
// RQ10 - pin pull-up connected unless pull-up disable bit in second config is set
// RQ11 - in break, ack write clears latch only when break clear enable is 1
// RQ12 - pin mask bit 1 blocks requests to CPU, 0 allows; reset clears
// RQ13 - sensitivity bit 1 selects edges plus low level, 0 edges; reset clears
// RQ14 - six keypad pins each enabled separately; enabling forces pull-up on
// RQ15 - keypad latches when enabled inputs go low after all high
// RQ16 - keypad level mode: pending while any low; clear needs ack and all high
// RQ17 - keypad ack write clears request, later falling edges latch again
// RQ18 - latched unmasked keypad request goes to CPU, vector FFE0/FFE1
// RQ19 - wakeup request cleared only by software keypad ack or reset
// RQ20 - keypad edge mode: fetch or software ack clears request at once
// RQ21 - reset clears keypad request and sensitivity bit even with input low
// RQ22 - keypad pending flag shows request regardless of keypad mask
// RQ23 - keypad mask 1 blocks keypad and wakeup requests to CPU; reset clears
// RQ24 - pin interrupt works only with function enable bit 1 in second config
// RQ25 - per-vector fetch strobe applied to matching latch in same cycle
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "ext_irq_defs.vh"
module external_interrupt_inputs #(
   parameter KEYS = 6
) (
   input wire aclk, // system bus clock
   input wire aresetn, // synchronous reset, active low
   input wire [4:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [4:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready, // read data ready
   input wire irq_pin_n, // external interrupt pin, active low
   input wire [KEYS-1:0] key_pin_n, // keypad pins, active low
   input wire wakeup_request_input, // wakeup request, on-clock
   input wire break_state, // cpu in break state, on-clock
   input wire pin_vector_fetch, // pin vector fetch strobe
   input wire keypad_vector_fetch, // keypad vector fetch strobe
   input wire [KEYS-1:0] port_pullup_enable, // port pull-up bits
   output wire pin_irq_request, // pin request to cpu
   output wire keypad_irq_request, // keypad request to cpu
   output reg pin_pullup_on, // pull-up connect on interrupt pin
   output reg [KEYS-1:0] key_pullup_on, // pull-up connect per keypad pin
   output reg branch_pin_level, // level seen by branch-if-pin instructions
   output reg port_a_bit_two_read // value port A bit two reads
);
   reg irq_s1_q, irq_s2_q, irq_s3_q;
   reg [KEYS-1:0] key_s1_q, key_s2_q;
   reg pin_latch_q, key_latch_q, key_any_low_q, wake_latch_q;
   reg pin_mode_q, pin_mask_q, key_mode_q, key_mask_q;
   reg [KEYS-1:0] key_enable_q;
   reg [7:0] cfg2_q, bfc_q;
   reg [4:0] awaddr_q;
   reg aw_held_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_held_q;
   wire do_write;
   wire wr_pin_sc, wr_key_sc, wr_key_en, wr_cfg2, wr_bfc, wr_ok;
   wire pin_func_en;
   wire ack_allowed;
   wire pin_sw_ack, key_sw_ack;
   wire pin_ack, key_ack;
   wire pin_fall, pin_low;
   wire [KEYS-1:0] key_low;
   wire key_any_low, key_fall;
   reg [31:0] rd_d;
   reg rd_ok;

   // pins cross into the bus clock through two flops first
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_s1_q <= 1'b1;
         irq_s2_q <= 1'b1;
         irq_s3_q <= 1'b1;
         key_s1_q <= {KEYS{1'b1}};
         key_s2_q <= {KEYS{1'b1}};
      end else begin
         irq_s1_q <= irq_pin_n;
         irq_s2_q <= irq_s1_q;
         irq_s3_q <= irq_s2_q;
         key_s1_q <= key_pin_n;
         key_s2_q <= key_s1_q;
      end
   end

   // write channel: address and data taken in either order, held until both present
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 5'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // all fields live in byte lane 0; other lanes are ignored
   assign wr_pin_sc = do_write && wstrb_q[0] && awaddr_q[4:2] == `ADDR_PIN_STATUS_CONTROL >> 2;
   assign wr_key_sc = do_write && wstrb_q[0] && awaddr_q[4:2] == `ADDR_KEYPAD_STATUS_CONTROL >> 2;
   assign wr_key_en = do_write && wstrb_q[0] && awaddr_q[4:2] == `ADDR_KEYPAD_ENABLE >> 2;
   assign wr_cfg2 = do_write && wstrb_q[0] && awaddr_q[4:2] == `ADDR_SECOND_CONFIG >> 2;
   assign wr_bfc = do_write && wstrb_q[0] && awaddr_q[4:2] == `ADDR_BREAK_FLAG_CONTROL >> 2;
   assign wr_ok = awaddr_q <= `ADDR_BREAK_FLAG_CONTROL;

   // control registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_mode_q <= 1'b0; // RQ6
         pin_mask_q <= 1'b0; // RQ12
         key_mode_q <= 1'b0; // RQ21
         key_mask_q <= 1'b0; // RQ23
         key_enable_q <= `RST_KEYPAD_ENABLE;
         cfg2_q <= `RST_SECOND_CONFIG;
         bfc_q <= `RST_BREAK_FLAG_CONTROL;
      end else begin
         if (wr_pin_sc) begin
            pin_mode_q <= wdata_q[`SC_MODE_BIT]; // RQ13
            pin_mask_q <= wdata_q[`SC_MASK_BIT]; // RQ12
         end
         if (wr_key_sc) begin
            key_mode_q <= wdata_q[`SC_MODE_BIT];
            key_mask_q <= wdata_q[`SC_MASK_BIT]; // RQ23
         end
         if (wr_key_en)
            key_enable_q <= wdata_q[KEYS-1:0]; // RQ14
         if (wr_cfg2)
            cfg2_q <= wdata_q[7:0];
         if (wr_bfc)
            bfc_q <= wdata_q[7:0];
      end
   end

   assign pin_func_en = cfg2_q[`CFG2_FUNC_EN_BIT]; // RQ24
   // in break, software acks count only with the break clear enable set
   assign ack_allowed = !break_state || bfc_q[`BFC_CLEAR_EN_BIT]; // RQ11
   assign pin_sw_ack = wr_pin_sc && wdata_q[`SC_ACK_BIT] && ack_allowed; // RQ3
   assign key_sw_ack = wr_key_sc && wdata_q[`SC_ACK_BIT] && ack_allowed; // RQ17
   assign pin_ack = pin_sw_ack || pin_vector_fetch; // RQ25
   assign key_ack = key_sw_ack || keypad_vector_fetch; // RQ25

   // pin latch
   assign pin_low = pin_func_en && !irq_s2_q;
   assign pin_fall = pin_func_en && irq_s3_q && !irq_s2_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_latch_q <= 1'b0; // RQ6
      end else if (pin_fall) begin
         pin_latch_q <= 1'b1; // RQ1 RQ4
      end else if (pin_ack) begin
         // in level mode the ack is remembered by clearing here; the low level alone then holds the request
         pin_latch_q <= 1'b0; // RQ7
      end
   end

   // keypad latch: a new request needs all enabled inputs high beforehand
   assign key_low = key_enable_q & ~key_s2_q;
   assign key_any_low = |key_low;
   assign key_fall = key_any_low && !key_any_low_q; // RQ15
   always @(posedge aclk) begin
      if (!aresetn) begin
         key_any_low_q <= 1'b0;
         key_latch_q <= 1'b0; // RQ21
         wake_latch_q <= 1'b0;
      end else begin
         key_any_low_q <= key_any_low;
         if (key_fall)
            key_latch_q <= 1'b1; // RQ15
         else if (key_ack)
            key_latch_q <= 1'b0; // RQ20
         // wakeup source ignores vector fetch; only software ack or reset clears it
         if (wakeup_request_input)
            wake_latch_q <= 1'b1;
         else if (key_sw_ack)
            wake_latch_q <= 1'b0; // RQ19
      end
   end

   // level mode keeps the request asserted while any enabled input is low
   // clearing needs both the ack (latch) and the release (level term), in either order
   assign pin_irq_request = (pin_latch_q || (pin_mode_q && pin_low)) && !pin_mask_q; // RQ2 RQ5
   assign keypad_irq_request = (key_latch_q || (key_mode_q && key_any_low) || wake_latch_q) // RQ16
      && !key_mask_q; // RQ18

   // pad-side outputs registered
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_pullup_on <= 1'b1;
         key_pullup_on <= {KEYS{1'b0}};
         branch_pin_level <= 1'b1;
         port_a_bit_two_read <= 1'b0;
      end else begin
         pin_pullup_on <= !cfg2_q[`CFG2_PULLUP_DIS_BIT]; // RQ10
         key_pullup_on <= key_enable_q | port_pullup_enable; // RQ14
         branch_pin_level <= pin_func_en ? irq_s2_q : 1'b1; // RQ9
         port_a_bit_two_read <= pin_func_en ? 1'b0 : irq_s2_q; // RQ9
      end
   end

   // read mux
   always @* begin
      rd_d = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr[4:2] == `ADDR_PIN_STATUS_CONTROL >> 2) begin
         rd_d[`SC_MODE_BIT] = pin_mode_q;
         rd_d[`SC_MASK_BIT] = pin_mask_q;
         rd_d[`SC_FLAG_BIT] = pin_latch_q || (pin_mode_q && pin_low); // RQ8
      end else if (s_axi_araddr[4:2] == `ADDR_KEYPAD_STATUS_CONTROL >> 2) begin
         rd_d[`SC_MODE_BIT] = key_mode_q;
         rd_d[`SC_MASK_BIT] = key_mask_q;
         rd_d[`SC_FLAG_BIT] = key_latch_q || (key_mode_q && key_any_low) || wake_latch_q; // RQ22
      end else if (s_axi_araddr[4:2] == `ADDR_KEYPAD_ENABLE >> 2) begin
         rd_d[KEYS-1:0] = key_enable_q;
      end else if (s_axi_araddr[4:2] == `ADDR_SECOND_CONFIG >> 2) begin
         rd_d[7:0] = cfg2_q;
      end else if (s_axi_araddr[4:2] == `ADDR_BREAK_FLAG_CONTROL >> 2) begin
         rd_d[7:0] = bfc_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- testbench/ext_irq_chk.sv ----
`timescale 1ns/1ps
module ext_irq_chk #(
   parameter KEYS = 6
) (
   input wire aclk, // clock
   input wire aresetn, // reset
   input wire s_axi_bvalid, // write answer
   input wire s_axi_rvalid, // read answer
   input wire [1:0] s_axi_rresp, // read status
   input wire [31:0] s_axi_rdata, // read data
   input wire irq_pin_n, // pin
   input wire [KEYS-1:0] key_pin_n, // keys
   input wire pin_vector_fetch, // pin fetch
   input wire keypad_vector_fetch, // key fetch
   input wire [KEYS-1:0] port_pullup_enable, // port pull-ups
   input wire pin_irq_request, // pin request
   input wire keypad_irq_request, // key request
   input wire [KEYS-1:0] key_pullup_on, // key pull-ups
   input wire branch_pin_level, // branch level
   input wire port_a_bit_two_read // port bit
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_clear: assert property ($rose(aresetn) |-> !pin_irq_request && !keypad_irq_request)
      else $error("request after reset");
   a_reset_out: assert property ($rose(aresetn) |-> branch_pin_level && !port_a_bit_two_read)
      else $error("pin function on after reset");
   a_pin_fetch: assert property (pin_vector_fetch && irq_pin_n && $past(irq_pin_n) && $past(irq_pin_n, 2)
      && $past(irq_pin_n, 3) |=> !pin_irq_request)
      else $error("fetch left pin request");
   a_pin_drop: assert property ($fell(pin_irq_request) |-> $past(pin_vector_fetch) || s_axi_bvalid || irq_pin_n)
      else $error("pin request dropped early");
   a_key_drop: assert property ($fell(keypad_irq_request) |-> $past(keypad_vector_fetch) || s_axi_bvalid
      || &key_pin_n)
      else $error("key request dropped early");
   a_branch_port: assert property (!branch_pin_level |-> !port_a_bit_two_read)
      else $error("port bit not zero");
   a_key_pullup: assert property ($past(aresetn) |-> (key_pullup_on & $past(port_pullup_enable))
      == $past(port_pullup_enable))
      else $error("key pull-up off");
   a_read_fields: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:8] == 24'h00_0000
      && !s_axi_rdata[2])
      else $error("bad read bits");
   cover property ($rose(pin_irq_request));
   cover property ($rose(keypad_irq_request));
   cover property (pin_vector_fetch);
endmodule

// ---- testbench/pin_cpu_model.sv ----
`timescale 1ns/1ps
module pin_cpu_model (
   input wire aclk, // clock
   input wire pin_irq_request, // pin request
   input wire keypad_irq_request, // key request
   input wire fetch_en, // cpu takes interrupts
   input wire pin_low, // pull pin low
   input wire [5:0] key_low, // pull keys low
   output logic irq_pin_n = 1'b1, // pin
   output logic [5:0] key_pin_n = 6'h3f, // keys
   output logic pin_vector_fetch = 1'b0, // pin fetch
   output logic keypad_vector_fetch = 1'b0 // key fetch
);
   always @(posedge aclk) begin
      // released lines are driven high by this model itself
      irq_pin_n <= !pin_low;
      key_pin_n <= ~key_low;
      pin_vector_fetch <= fetch_en && pin_irq_request && !pin_vector_fetch;
      keypad_vector_fetch <= fetch_en && keypad_irq_request && !pin_irq_request && !keypad_vector_fetch;
   end
endmodule

// ---- testbench/external_interrupt_inputs_bench.sv ----
`timescale 1ns/1ps
`include "ext_irq_defs.vh"
module external_interrupt_inputs_bench;
   localparam KEYS = 6;
   localparam [4:0] PSC = `ADDR_PIN_STATUS_CONTROL;
   localparam [4:0] KSC = `ADDR_KEYPAD_STATUS_CONTROL;
   localparam [4:0] CFG = `ADDR_SECOND_CONFIG;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, wakeup_request_input = 0, break_state = 0, fetch_en = 0, pin_low = 0;
   logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] r;
   logic [KEYS-1:0] port_pullup_enable = 6'h30, key_low = '0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_pin_n;
   wire pin_vector_fetch, keypad_vector_fetch, pin_irq_request, keypad_irq_request;
   wire pin_pullup_on, branch_pin_level, port_a_bit_two_read;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [KEYS-1:0] key_pin_n, key_pullup_on;
   int err_count = 0, samples_checked = 0, cycles = 0;
   external_interrupt_inputs #(.KEYS(KEYS)) external_interrupt_inputs_inst (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq_pin_n, .key_pin_n, .wakeup_request_input, .break_state,
      .pin_vector_fetch, .keypad_vector_fetch, .port_pullup_enable, .pin_irq_request, .keypad_irq_request,
      .pin_pullup_on, .key_pullup_on, .branch_pin_level, .port_a_bit_two_read);
   pin_cpu_model pin_cpu_model_inst (.aclk, .pin_irq_request, .keypad_irq_request, .fetch_en, .pin_low,
      .key_low, .irq_pin_n, .key_pin_n, .pin_vector_fetch, .keypad_vector_fetch);
   always #20 aclk = ~aclk;
   task automatic chk(input [31:0] s, input [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input [4:0] a, input [7:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task automatic rc(input [4:0] a, input [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      chk(d, e);
   endtask
   task automatic rst;
      aresetn <= 0;
      cyc(2);
      aresetn <= 1;
      cyc(1);
   endtask
   task automatic t_reset;
      chk(32'(branch_pin_level), 1);
      for (int a = 0; a <= 16; a += 4) rc(5'(a), 0);
      rc(5'h14, 0);
      chk(32'(r), 2);
      pin_low <= 1;
      cyc(6);
      chk(32'(pin_irq_request), 0);
      chk(32'(branch_pin_level), 1);
      chk(32'(port_a_bit_two_read), 0);
      pin_low <= 0;
      wr(CFG, 8'h03);
      cyc(2);
      chk(32'(pin_pullup_on), 0);
   endtask
   task automatic t_pin;
      wr(CFG, 8'h02);
      pin_low <= 1;
      cyc(6);
      chk(32'(pin_irq_request), 1);
      chk(32'(branch_pin_level), 0);
      chk(32'(port_a_bit_two_read), 0);
      rc(PSC, 8'h08);
      pin_low <= 0;
      wr(PSC, 8'h04);
      chk(32'(pin_irq_request), 0);
      pin_low <= 1;
      cyc(6);
      chk(32'(pin_irq_request), 1);
      wr(PSC, 8'h02);
      chk(32'(pin_irq_request), 0);
      rc(PSC, 8'h0a);
      pin_low <= 0;
      fetch_en <= 1;
      cyc(4);
      wr(PSC, 8'h00);
      cyc(4);
      chk(32'(pin_irq_request), 0);
      fetch_en <= 0;
   endtask
   task automatic t_level;
      wr(PSC, 8'h01);
      pin_low <= 1;
      cyc(6);
      wr(PSC, 8'h05);
      chk(32'(pin_irq_request), 1);
      rc(PSC, 8'h09);
      pin_low <= 0;
      cyc(6);
      chk(32'(pin_irq_request), 0);
      pin_low <= 1;
      cyc(6);
      rst();
      chk(32'(pin_irq_request), 0);
      rc(PSC, 8'h00);
      pin_low <= 0;
   endtask
   task automatic t_break;
      wr(CFG, 8'h02);
      pin_low <= 1;
      cyc(6);
      pin_low <= 0;
      break_state <= 1;
      wr(PSC, 8'h04);
      chk(32'(pin_irq_request), 1);
      wr(`ADDR_BREAK_FLAG_CONTROL, 8'h80);
      wr(PSC, 8'h04);
      break_state <= 0;
      cyc(2);
      chk(32'(pin_irq_request), 0);
   endtask
   task automatic t_key;
      wr(`ADDR_KEYPAD_ENABLE, 8'h03);
      cyc(2);
      chk(32'(key_pullup_on), 6'h33);
      key_low <= 6'h01;
      cyc(6);
      rc(KSC, 8'h08);
      wr(KSC, 8'h04);
      key_low <= 6'h03;
      cyc(6);
      chk(32'(keypad_irq_request), 0);
      key_low <= 6'h04;
      cyc(6);
      chk(32'(keypad_irq_request), 0);
      key_low <= 6'h00;
      wakeup_request_input <= 1;
      fetch_en <= 1;
      cyc(1);
      wakeup_request_input <= 0;
      cyc(6);
      chk(32'(keypad_irq_request), 1);
      fetch_en <= 0;
      wr(KSC, 8'h02);
      rc(KSC, 8'h0a);
      chk(32'(keypad_irq_request), 0);
      wr(KSC, 8'h05);
      chk(32'(keypad_irq_request), 0);
      key_low <= 6'h02;
      cyc(6);
      wr(KSC, 8'h05);
      chk(32'(keypad_irq_request), 1);
      rst();
      chk(32'(keypad_irq_request), 0);
   endtask
   task test_done;
      $display("compared %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      cyc(20);
      aresetn <= 1;
      cyc(1);
      t_reset();
      t_pin();
      t_level();
      t_break();
      t_key();
      test_done();
   end
endmodule
bind external_interrupt_inputs ext_irq_chk #(.KEYS(KEYS)) ext_irq_chk_inst (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .irq_pin_n, .key_pin_n, .pin_vector_fetch, .keypad_vector_fetch,
   .port_pullup_enable, .pin_irq_request, .keypad_irq_request, .key_pullup_on, .branch_pin_level,
   .port_a_bit_two_read);
